//--- hdl/nsc_pkg.sv
// Constants, field layout and types shared by the sensor configuration block.
// Assumes a single 40 MHz clock and an AHB-Lite bus with word registers.
package nsc_pkg;

    // Printed register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_SENSOR_CONFIGURATION   = 6'h0a;
    localparam logic [5:0] IDX_EXTENDED_CONFIGURATION = 6'h0b;
    localparam logic [5:0] IDX_DATA_OUT_LOWER         = 6'h0c;
    localparam logic [5:0] IDX_DATA_OUT_UPPER         = 6'h0d;
    localparam logic [5:0] IDX_IRQ_STATUS             = 6'h10;
    localparam logic [5:0] IDX_IRQ_MASK               = 6'h11;

    // Field positions in the sensor configuration register.
    localparam int CFG_LASER_MODE_POS = 6;
    localparam int CFG_SELF_TEST_POS  = 5;
    localparam int CFG_RES_HIGH_POS   = 4;
    localparam int CFG_RES_LOW_POS    = 2;

    // Field positions in the extended configuration register.
    localparam int EXT_BUSY_POS          = 7;
    localparam int EXT_PULLUP_DIS_POS    = 2;
    localparam int EXT_GAIN_CTRL_DIS_POS = 1;
    localparam int EXT_CONST_FR_POS      = 0;
    localparam int EXT_STORE_W           = 4;

    // Reset values.
    localparam logic [7:0] CFG_RESET = 8'h49;
    localparam logic [7:0] EXT_RESET = 8'h08;

    // Self-test answers.
    localparam logic [15:0] TEST_PASS_RESULT = 16'ha9d5;
    localparam logic [15:0] TEST_FAIL_RESULT = 16'h0000;

    // Interrupt status bits.
    localparam int IRQ_W          = 3;
    localparam int IRQ_TEST_DONE  = 0;
    localparam int IRQ_TEST_FAIL  = 1;
    localparam int IRQ_BUSY_CLEAR = 2;

    // Timing: the self test lasts 200 ms at the 40 MHz clock.
    localparam longint CLK_HZ        = 64'd40_000_000;
    localparam longint TEST_TIME_MS  = 64'd200;
    localparam longint TEST_CYCLES_L = TEST_TIME_MS * CLK_HZ / 64'd1000;
    localparam int     TEST_CYCLES_DFLT = int'(TEST_CYCLES_L);
    localparam int     TEST_CNT_W    = 24;
    localparam logic [1:0] BUSY_FRAMES = 2'h2;

    // Bus encodings.
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic {NSC_IDLE, NSC_RUN} nsc_test_state_e;

endpackage : nsc_pkg

//--- hdl/nsc_test_if.sv
// Handshake between the register logic and the self-test engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface nsc_test_if;
    logic        start;
    logic        laserFault;
    logic        fwLoaded;
    logic        running;
    logic        done;
    logic        failed;
    logic [15:0] result;

    modport ctrl   (output start, laserFault, fwLoaded,
                    input  running, done, failed, result);
    modport engine (input  start, laserFault, fwLoaded,
                    output running, done, failed, result);
endinterface : nsc_test_if

//--- hdl/nsc_self_test.sv
// Self-test engine: runs for a fixed count of cycles and grades the run.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
module nsc_self_test
    import nsc_pkg::*;
#(
    parameter int TEST_CYCLES = TEST_CYCLES_DFLT
) (
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic       ce,
    nsc_test_if.engine     tst
);
    localparam logic [TEST_CNT_W-1:0] LAST_CNT =
        TEST_CNT_W'(TEST_CYCLES - 1);

    nsc_test_state_e        state_ff, nxt_state;
    logic [TEST_CNT_W-1:0]  cnt_ff, nxt_cnt;
    logic                   fail_ff, nxt_fail;
    logic                   done_ff, nxt_done;
    logic [15:0]            result_ff, nxt_result;

    // Next state: a loaded firmware image or any fault grades a fail.
    always_comb begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_fail   = fail_ff;
        nxt_done   = 1'b0;
        nxt_result = result_ff;
        case (state_ff)
            NSC_IDLE: begin
                if (tst.start) begin
                    nxt_state = NSC_RUN;
                    nxt_cnt   = '0;
                    nxt_fail  = tst.fwLoaded | tst.laserFault;
                end
            end
            NSC_RUN: begin
                nxt_cnt  = cnt_ff + 1'b1;
                nxt_fail = fail_ff | tst.laserFault;
                if (cnt_ff == LAST_CNT) begin
                    nxt_state  = NSC_IDLE;
                    nxt_done   = 1'b1;
                    nxt_result = nxt_fail ? TEST_FAIL_RESULT
                                          : TEST_PASS_RESULT;
                end
            end
            default: nxt_state = NSC_IDLE;
        endcase
    end

    // State registers, frozen while the clock enable is low.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_ff  <= NSC_IDLE;
            cnt_ff    <= '0;
            fail_ff   <= 1'b0;
            done_ff   <= 1'b0;
            result_ff <= 16'h0000;
        end else if (ce) begin
            state_ff  <= nxt_state;
            cnt_ff    <= nxt_cnt;
            fail_ff   <= nxt_fail;
            done_ff   <= nxt_done;
            result_ff <= nxt_result;
        end
    end

    assign tst.running = (state_ff == NSC_RUN);
    assign tst.done    = done_ff & ce;
    assign tst.failed  = fail_ff;
    assign tst.result  = result_ff;

    property p_fw_fail;
        @(posedge ref_clk) disable iff (reset)
        ce && state_ff == NSC_IDLE && tst.start && tst.fwLoaded |=> fail_ff;
    endproperty
    a_fw_fail: assert property (p_fw_fail)
        else $error("Loaded firmware did not mark the test failed.");

    property p_fault_fail;
        @(posedge ref_clk) disable iff (reset)
        ce && state_ff == NSC_RUN && tst.laserFault |=> fail_ff;
    endproperty
    a_fault_fail: assert property (p_fault_fail)
        else $error("Laser fault during test did not mark failure.");

    property p_duration;
        @(posedge ref_clk) disable iff (reset)
        ce && state_ff == NSC_RUN && cnt_ff == LAST_CNT
            |=> done_ff && state_ff == NSC_IDLE;
    endproperty
    a_duration: assert property (p_duration)
        else $error("Self test did not end at its cycle count.");

    c_test_fail: cover property (@(posedge ref_clk) disable iff (reset)
        done_ff && fail_ff);
endmodule : nsc_self_test

//--- hdl/nsc_busy_tracker.sv
// Busy flag that stands for two frames after the upper frame bound write.
// Assumes boundWrite and frameTick are one-cycle pulses on the same clock.
`timescale 1ns/1ps
module nsc_busy_tracker
    import nsc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic ce,
    input  wire logic boundWrite,
    input  wire logic frameTick,
    output logic      busy,
    output logic      busyCleared
);
    logic       busy_ff, nxt_busy;
    logic [1:0] frames_ff, nxt_frames;
    logic       cleared_ff, nxt_cleared;

    // A new write restarts the frame count, so the flag never drops early.
    always_comb begin
        nxt_busy    = busy_ff;
        nxt_frames  = frames_ff;
        nxt_cleared = 1'b0;
        if (boundWrite) begin
            nxt_busy   = 1'b1;
            nxt_frames = 2'h0;
        end else if (busy_ff && frameTick) begin
            nxt_frames = frames_ff + 2'h1;
            if (nxt_frames == BUSY_FRAMES) begin
                nxt_busy    = 1'b0;
                nxt_cleared = 1'b1;
            end
        end
    end

    // Registers frozen while the clock enable is low.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            busy_ff    <= 1'b0;
            frames_ff  <= 2'h0;
            cleared_ff <= 1'b0;
        end else if (ce) begin
            busy_ff    <= nxt_busy;
            frames_ff  <= nxt_frames;
            cleared_ff <= nxt_cleared;
        end
    end

    assign busy        = busy_ff;
    assign busyCleared = cleared_ff & ce;

    property p_busy_hold;
        @(posedge ref_clk) disable iff (reset)
        busy_ff && !$past(busy_ff) |-> frames_ff == 2'h0;
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("Busy rose without restarting the frame count.");

    property p_busy_drop;
        @(posedge ref_clk) disable iff (reset)
        $fell(busy_ff) |-> $past(frames_ff) == 2'h1 && $past(frameTick);
    endproperty
    a_busy_drop: assert property (p_busy_drop)
        else $error("Busy fell before two frames had passed.");
endmodule : nsc_busy_tracker

//--- hdl/nsc_config_regs.sv
// Configuration register block of an optical navigation sensor.
// Assumes an AHB-Lite master, one clock and a synchronous active-high reset.
//
// Overview of operation
// - Shutter mode bit gates laser on demand
// - Self-test bit runs test, 16-bit result out
// - Loaded firmware memory fails the test
// - Laser fault during test fails it
// - Test completion restores defaults and RAM
// - Test lasts 200 ms
// - Bits four and two select resolution
// - Busy stands two frames after bound write
// - Pull-up disable turns serial pull-ups off
// - Gain-control disable stops AGC, shutter maximum
// - Constant frame rate disables automatic control
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
module nsc_config_regs
    import nsc_pkg::*;
#(
    parameter int TEST_CYCLES = TEST_CYCLES_DFLT
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        illuminationNeeded,
    input  wire logic        laserFaultPin,
    input  wire logic        firmwareMemoryLoaded,
    input  wire logic        frameBoundUpperWrite,
    input  wire logic        frameTick,
    output logic             laserEnable,
    output logic [1:0]       cpiSelect,
    output logic             pullupEnable,
    output logic             agcEnable,
    output logic             shutterUseMaxBound,
    output logic             autoFrameRate,
    output logic             selfTestRunning,
    output logic             ramRestore,
    output logic             irq
);

    nsc_test_if tst ();

    logic busyFlag;
    logic busyCleared;

    // Laser fault arrives from a pin: three stages, change taken on agreement.
    logic faultSync1_ff, faultSync2_ff, faultSync3_ff;
    logic faultLevel_ff, nxt_faultLevel;

    always_comb begin
        nxt_faultLevel = faultLevel_ff;
        if (faultSync2_ff == faultSync3_ff) begin
            nxt_faultLevel = faultSync3_ff;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            faultSync1_ff <= 1'b0;
            faultSync2_ff <= 1'b0;
            faultSync3_ff <= 1'b0;
            faultLevel_ff <= 1'b0;
        end else if (ce) begin
            faultSync1_ff <= laserFaultPin;
            faultSync2_ff <= faultSync1_ff;
            faultSync3_ff <= faultSync2_ff;
            faultLevel_ff <= nxt_faultLevel;
        end
    end

    // Bus state: the address phase is captured, the write lands in the data
    // phase; the slave never inserts wait states.
    logic        wrPend_ff, nxt_wrPend;
    logic [5:0]  wrIdx_ff, nxt_wrIdx;
    logic [31:0] hrdata_ff, nxt_hrdata;
    logic        hreadyout_ff;

    // Register state.
    logic [7:0]             cfg_ff, nxt_cfg;
    logic [EXT_STORE_W-1:0] ext_ff, nxt_ext;
    logic [15:0]            dataOut_ff, nxt_dataOut;
    logic [IRQ_W-1:0]       irqStat_ff, nxt_irqStat;
    logic [IRQ_W-1:0]       irqMask_ff, nxt_irqMask;

    // Output state.
    logic       laserEnable_ff, nxt_laserEnable;
    logic [1:0] cpiSelect_ff, nxt_cpiSelect;
    logic       pullupEnable_ff, nxt_pullupEnable;
    logic       agcEnable_ff, nxt_agcEnable;
    logic       shutterMax_ff, nxt_shutterMax;
    logic       autoFr_ff, nxt_autoFr;
    logic       running_ff, nxt_running;
    logic       ramRestore_ff, nxt_ramRestore;
    logic       irq_ff, nxt_irq;

    logic             addrValid;
    logic             cfgWrite;
    logic             extWrite;
    logic             statWrite;
    logic             maskWrite;
    logic [IRQ_W-1:0] irqSet;
    logic [7:0]       rdByte;

    // Address decode and write strobes for the data phase.
    always_comb begin
        addrValid  = hsel && hready && htrans[1];
        nxt_wrPend = addrValid && hwrite;
        nxt_wrIdx  = addrValid ? haddr[7:2] : wrIdx_ff;
        cfgWrite   = wrPend_ff && (wrIdx_ff == IDX_SENSOR_CONFIGURATION);
        extWrite   = wrPend_ff && (wrIdx_ff == IDX_EXTENDED_CONFIGURATION);
        statWrite  = wrPend_ff && (wrIdx_ff == IDX_IRQ_STATUS);
        maskWrite  = wrPend_ff && (wrIdx_ff == IDX_IRQ_MASK);
    end

    // Test launch: a one written to the self-test bit while idle.
    assign tst.start      = cfgWrite && hwdata[CFG_SELF_TEST_POS]
                            && !tst.running;
    assign tst.laserFault = faultLevel_ff;
    assign tst.fwLoaded   = firmwareMemoryLoaded;

    // Register updates. Config and extended writes during a test are dropped, since the test
    // reloads defaults at its end and would discard them anyway.
    always_comb begin
        nxt_cfg     = cfg_ff;
        nxt_ext     = ext_ff;
        nxt_dataOut = dataOut_ff;
        nxt_irqMask = irqMask_ff;
        if (cfgWrite && !tst.running) begin
            nxt_cfg = hwdata[7:0];
        end
        if (extWrite && !tst.running) begin
            nxt_ext = hwdata[EXT_STORE_W-1:0];
        end
        if (maskWrite) begin
            nxt_irqMask = hwdata[IRQ_W-1:0];
        end
        if (tst.done) begin
            nxt_dataOut = tst.result;
            nxt_cfg     = CFG_RESET;
            nxt_ext     = EXT_RESET[EXT_STORE_W-1:0];
        end
    end

    // Sticky interrupt status: a set in the cycle of a clear wins.
    always_comb begin
        irqSet = '0;
        irqSet[IRQ_TEST_DONE]  = tst.done;
        irqSet[IRQ_TEST_FAIL]  = tst.done && tst.failed;
        irqSet[IRQ_BUSY_CLEAR] = busyCleared;
        nxt_irqStat = irqStat_ff;
        if (statWrite) begin
            nxt_irqStat = irqStat_ff & ~hwdata[IRQ_W-1:0];
        end
        nxt_irqStat = nxt_irqStat | irqSet;
        nxt_irq     = |(nxt_irqStat & nxt_irqMask);
    end

    // Read data use the next values so a read right after a write sees it.
    always_comb begin
        case (haddr[7:2])
            IDX_SENSOR_CONFIGURATION:   rdByte = nxt_cfg;
            IDX_EXTENDED_CONFIGURATION: rdByte = {busyFlag, 3'h0, nxt_ext};
            IDX_DATA_OUT_LOWER:         rdByte = nxt_dataOut[7:0];
            IDX_DATA_OUT_UPPER:         rdByte = nxt_dataOut[15:8];
            IDX_IRQ_STATUS:             rdByte = {5'h00, nxt_irqStat};
            IDX_IRQ_MASK:               rdByte = {5'h00, nxt_irqMask};
            default:                    rdByte = 8'h00;
        endcase
        nxt_hrdata = hrdata_ff;
        if (addrValid && !hwrite) begin
            nxt_hrdata = {24'h000000, rdByte};
        end
    end

    // Control outputs derived from the stored fields and the self-test engine.
    always_comb begin
        nxt_laserEnable  = cfg_ff[CFG_LASER_MODE_POS]
                           ? illuminationNeeded : 1'b1;
        nxt_cpiSelect    = {cfg_ff[CFG_RES_HIGH_POS],
                            cfg_ff[CFG_RES_LOW_POS]};
        nxt_pullupEnable = !ext_ff[EXT_PULLUP_DIS_POS];
        nxt_agcEnable    = !ext_ff[EXT_GAIN_CTRL_DIS_POS];
        nxt_shutterMax   = ext_ff[EXT_GAIN_CTRL_DIS_POS];
        nxt_autoFr       = !ext_ff[EXT_CONST_FR_POS];
        nxt_running      = tst.running;
        nxt_ramRestore   = tst.done;
    end

    // All block state, frozen while the clock enable is low.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wrPend_ff       <= 1'b0;
            wrIdx_ff        <= 6'h00;
            hrdata_ff       <= 32'h00000000;
            hreadyout_ff    <= 1'b1;
            cfg_ff          <= CFG_RESET;
            ext_ff          <= EXT_RESET[EXT_STORE_W-1:0];
            dataOut_ff      <= 16'h0000;
            irqStat_ff      <= '0;
            irqMask_ff      <= '0;
            laserEnable_ff  <= 1'b1;
            cpiSelect_ff    <= 2'h0;
            pullupEnable_ff <= 1'b1;
            agcEnable_ff    <= 1'b1;
            shutterMax_ff   <= 1'b0;
            autoFr_ff       <= 1'b1;
            running_ff      <= 1'b0;
            ramRestore_ff   <= 1'b0;
            irq_ff          <= 1'b0;
        end else if (ce) begin
            wrPend_ff       <= nxt_wrPend;
            wrIdx_ff        <= nxt_wrIdx;
            hrdata_ff       <= nxt_hrdata;
            hreadyout_ff    <= 1'b1;
            cfg_ff          <= nxt_cfg;
            ext_ff          <= nxt_ext;
            dataOut_ff      <= nxt_dataOut;
            irqStat_ff      <= nxt_irqStat;
            irqMask_ff      <= nxt_irqMask;
            laserEnable_ff  <= nxt_laserEnable;
            cpiSelect_ff    <= nxt_cpiSelect;
            pullupEnable_ff <= nxt_pullupEnable;
            agcEnable_ff    <= nxt_agcEnable;
            shutterMax_ff   <= nxt_shutterMax;
            autoFr_ff       <= nxt_autoFr;
            running_ff      <= nxt_running;
            ramRestore_ff   <= nxt_ramRestore;
            irq_ff          <= nxt_irq;
        end
    end

    // Engine and busy tracker.
    nsc_self_test #(
        .TEST_CYCLES (TEST_CYCLES)
    ) u_self_test (
        .ref_clk (ref_clk),
        .reset   (reset),
        .ce      (ce),
        .tst     (tst.engine)
    );

    nsc_busy_tracker u_busy (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .ce          (ce),
        .boundWrite  (frameBoundUpperWrite),
        .frameTick   (frameTick),
        .busy        (busyFlag),
        .busyCleared (busyCleared)
    );

    assign hreadyout          = hreadyout_ff;
    assign hrdata             = hrdata_ff;
    assign hresp              = HRESP_OKAY;
    assign laserEnable        = laserEnable_ff;
    assign cpiSelect          = cpiSelect_ff;
    assign pullupEnable       = pullupEnable_ff;
    assign agcEnable          = agcEnable_ff;
    assign shutterUseMaxBound = shutterMax_ff;
    assign autoFrameRate      = autoFr_ff;
    assign selfTestRunning    = running_ff;
    assign ramRestore         = ramRestore_ff;
    assign irq                = irq_ff;

    // Checks on the configuration outputs and the test sequence.
    // Attempts at a reset edge are skipped: the registers take reset values.
    property p_laser_on;
        @(posedge ref_clk) disable iff (reset)
        !reset && ce && !cfg_ff[CFG_LASER_MODE_POS] |=> laserEnable_ff;
    endproperty
    a_laser_on: assert property (p_laser_on)
        else $error("Laser not held on with shutter mode off.");

    property p_laser_gate;
        @(posedge ref_clk) disable iff (reset)
        !reset && ce && cfg_ff[CFG_LASER_MODE_POS] && !illuminationNeeded
            |=> !laserEnable_ff;
    endproperty
    a_laser_gate: assert property (p_laser_gate)
        else $error("Laser on without need in shutter mode.");

    property p_result;
        @(posedge ref_clk) disable iff (reset)
        tst.done |=> dataOut_ff == $past(tst.result) && ramRestore_ff;
    endproperty
    a_result: assert property (p_result)
        else $error("Test result not presented at completion.");

    property p_restore;
        @(posedge ref_clk) disable iff (reset)
        tst.done |=> cfg_ff == CFG_RESET
            && ext_ff == EXT_RESET[EXT_STORE_W-1:0];
    endproperty
    a_restore: assert property (p_restore)
        else $error("Defaults not restored when the test ended.");

    property p_resolution;
        @(posedge ref_clk) disable iff (reset)
        !reset && ce ##1 ce |-> cpiSelect_ff ==
            {$past(cfg_ff[CFG_RES_HIGH_POS]), $past(cfg_ff[CFG_RES_LOW_POS])};
    endproperty
    a_resolution: assert property (p_resolution)
        else $error("Resolution select does not follow bits four and two.");

    property p_ext_outputs;
        @(posedge ref_clk) disable iff (reset)
        ce && extWrite && !tst.running && !tst.done ##1 ce
            |=> pullupEnable_ff == !$past(hwdata[EXT_PULLUP_DIS_POS], 2)
            && agcEnable_ff == !$past(hwdata[EXT_GAIN_CTRL_DIS_POS], 2)
            && shutterMax_ff == $past(hwdata[EXT_GAIN_CTRL_DIS_POS], 2)
            && autoFr_ff == !$past(hwdata[EXT_CONST_FR_POS], 2);
    endproperty
    a_ext_outputs: assert property (p_ext_outputs)
        else $error("Extended controls do not follow the written value.");

    property p_irq;
        @(posedge ref_clk) disable iff (reset)
        !reset && ce |=> irq_ff == |($past(nxt_irqStat) & $past(nxt_irqMask));
    endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt level does not match masked status.");

    c_test_start: cover property (@(posedge ref_clk) disable iff (reset)
        tst.start);
    c_test_done: cover property (@(posedge ref_clk) disable iff (reset)
        tst.done && !tst.failed);
    c_busy_clear: cover property (@(posedge ref_clk) disable iff (reset)
        busyCleared);

endmodule : nsc_config_regs

//--- test/nsc_host_model.sv
// Host side model: an AHB-Lite master doing single word transfers.
// Assumes hready is the slave's hreadyout.
`timescale 1ns/1ps
module nsc_host_model (
    input  wire logic        ref_clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [7:0]       haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    // The bus idles until the first transfer.
    initial begin
        {hsel, haddr, htrans, hwrite, hsize, hwdata} = 47'h0;
    end

    // Address phase, then data phase; each held until hready is seen.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        {hsel, htrans, hwrite, haddr, hsize} <= {3'h6, w, a, 3'h2};
        do @(posedge ref_clk); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {3'h0, d};
        do @(posedge ref_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : xfer
endmodule : nsc_host_model

//--- test/tb_nsc_config_regs.sv
// Self-checking bench for the sensor configuration registers.
// Assumes the host model as bus master and a shortened self test.
`timescale 1ns/1ps
module tb_nsc_config_regs;
    import nsc_pkg::*;
    localparam int TC = 20;
    logic        ref_clk, rst0, hsel, hwrite, hreadyout, hresp, irq;
    logic        illum, fault, fwLoad, laserEn, pullupEn, agcEn, useMax;
    logic        autoFr, running, ramRestore, ceOn;
    logic [1:0]  htrans, cpi;
    logic [2:0]  hsize, pls;
    logic [7:0]  haddr;
    logic [31:0] hwdata, hrdata, q;
    // Rows: config byte, extended byte, expected output bits.
    logic [22:0] rows [5] = '{{8'h48, 8'h08, 7'h1a}, {8'h58, 8'h0c, 7'h4a},
        {8'h4c, 8'h0a, 7'h36}, {8'h5c, 8'h09, 7'h78}, {8'h1c, 8'h0f, 7'h65}};
    int          nFail = 0, cmpCount = 0, n;

    nsc_config_regs #(.TEST_CYCLES(TC)) i_nsc_config_regs (
        .ref_clk(ref_clk), .reset(rst0 | pls[0]), .ce(ceOn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .illuminationNeeded(illum),
        .laserFaultPin(fault), .firmwareMemoryLoaded(fwLoad),
        .frameBoundUpperWrite(pls[1]), .frameTick(pls[2]),
        .laserEnable(laserEn), .cpiSelect(cpi), .pullupEnable(pullupEn),
        .agcEnable(agcEn), .shutterUseMaxBound(useMax),
        .autoFrameRate(autoFr), .selfTestRunning(running),
        .ramRestore(ramRestore), .irq(irq));
    nsc_host_model i_nsc_host_model (
        .ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmpCount, nFail);
        if (nFail == 0 && cmpCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        cmpCount++;
        if (g !== e) begin
            nFail++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic rd(logic [7:0] a, logic [31:0] e);
        i_nsc_host_model.xfer(1'b0, a, 32'h0, q);
        chk("hrdata", e, q);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : rd
    task automatic wr(logic [7:0] a, logic [31:0] d);
        i_nsc_host_model.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic pulse(logic [2:0] m);
        @(posedge ref_clk);
        pls <= m;
        @(posedge ref_clk);
        pls <= 3'h0;
    endtask : pulse
    // Reset, mask, start, then wait for the restore pulse, checking running on the third cycle.
    task automatic run_test(logic f, logic lf, logic [2:0] m,
                            logic [7:0] lo, logic [7:0] hi, logic [2:0] st);
        fwLoad <= f;
        pulse(3'h1);
        wr(8'h44, {29'h0, m});
        wr(8'h28, 32'h69);
        fault <= lf;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
            if (n == 3) chk("running", 32'h1, {31'h0, running});
        end while (ramRestore !== 1'b1 && n < 100);
        chk("cycles", 32'(TC + 2), 32'(n));
        rd(8'h30, {24'h0, lo});
        rd(8'h34, {24'h0, hi});
        rd(8'h28, 32'h49);
        rd(8'h2c, 32'h08);
        rd(8'h40, {29'h0, st});
        chk("irq", {31'h0, |(st & m)}, {31'h0, irq});
        fault <= 1'b0;
        wr(8'h40, 32'h7);
        rd(8'h40, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        wr(8'h28, 32'h5c);
        rd(8'h28, 32'h5c);
        fwLoad <= 1'b1;
    endtask : run_test

    // The clock toggles every half period of 12.5 ns.
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Watchdog at about eighteen times the expected length of the run.
    initial begin
        #(25 * 5000);
        nFail++;
        tally_and_finish();
    end
    // Main sequence: reset values, the row table, then the awkward cases.
    initial begin
        {rst0, ceOn, illum, fault, fwLoad, pls} = 8'hc0;
        repeat (6) @(posedge ref_clk);
        rst0 <= 1'b0;
        rd(8'h28, 32'h49);
        rd(8'h2c, 32'h08);
        foreach (rows[i]) begin
            wr(8'h28, {24'h0, rows[i][22:15]});
            wr(8'h2c, {24'h0, rows[i][14:7]});
            rd(8'h28, {24'h0, rows[i][22:15]});
            rd(8'h2c, {28'h0, rows[i][10:7]});
            chk("outputs", {25'h0, rows[i][6:0]},
                {25'h0, cpi, pullupEn, agcEn, useMax, autoFr, laserEn});
        end
        illum <= 1'b1;
        wr(8'h28, 32'h48);
        rd(8'h50, 32'h0);
        chk("laser", 32'h1, {31'h0, laserEn});
        $display("test registers done");
        run_test(1'b0, 1'b0, 3'h7, 8'hd5, 8'ha9, 3'h1);
        run_test(1'b1, 1'b0, 3'h7, 8'h00, 8'h00, 3'h3);
        run_test(1'b0, 1'b1, 3'h0, 8'h00, 8'h00, 3'h3);
        $display("test self test done");
        pulse(3'h2);
        rd(8'h2c, 32'h88);
        pulse(3'h4);
        rd(8'h2c, 32'h88);
        pulse(3'h4);
        rd(8'h2c, 32'h08);
        rd(8'h40, 32'h4);
        ceOn <= 1'b0;
        pulse(3'h2);
        ceOn <= 1'b1;
        rd(8'h2c, 32'h08);
        $display("test busy done");
        tally_and_finish();
    end
endmodule : tb_nsc_config_regs
